//--- bench/abrc_board_model.sv
// Neighbouring boards on the wired-OR control bus
`timescale 1ns/1ps
module abrc_board_model (
  input  wire logic own_busy_i,
  input  wire logic own_busy_oe_n_i,
  input  wire logic own_ready_i,
  input  wire logic own_ready_oe_n_i,
  input  wire logic peer_busy_i,
  input  wire logic peer_ready_i,
  output logic      busy_wire_o,
  output logic      ready_wire_o
);
  // wired-OR of all boards
  // Released lines fall to the termination level, never hold
  assign busy_wire_o  = (!own_busy_oe_n_i && own_busy_i) || peer_busy_i;
  assign ready_wire_o = (!own_ready_oe_n_i && own_ready_i) || peer_ready_i;
endmodule

//--- bench/abrc_monitor.sv
// Concurrent checks on the control block ports
`timescale 1ns/1ps
module abrc_monitor #(
  parameter int CONV_CYC = 228,
  parameter int CNT_W    = 24,
  parameter int EVENTS   = 32
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic             wb_we_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic             busy_line_o,
  input wire logic             busy_line_oe_n_o,
  input wire logic             data_ready_line_o,
  input wire logic             data_ready_line_oe_n_o,
  input wire logic             conv_start_o,
  input wire logic             data_reset_o,
  input wire logic             soft_reset_o,
  input wire logic             busy_lamp_o,
  input wire logic             access_ack_indicator_o,
  input wire logic [CNT_W-1:0] event_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_bus_busy_drive:
    assert property (!busy_line_oe_n_o |-> busy_line_o && busy_lamp_o) else $error("busy drive");
  chk_ready_drive:
    assert property (!data_ready_line_oe_n_o |-> data_ready_line_o) else $error("ready drive");
  chk_common_ignored:
    assert property (conv_start_o |=> (!conv_start_o)[*8]) else $error("common while busy");
  chk_start_sets_busy:
    assert property (conv_start_o |-> ##[0:2] !busy_line_oe_n_o) else $error("start not busy");
  chk_soft_has_data:
    assert property (soft_reset_o |-> data_reset_o) else $error("soft without data reset");
  chk_single_shot:
    assert property (wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == abrc_pkg::ADDR_SINGLE
      |=> soft_reset_o) else $error("single shot missed");
  chk_count_cleared:
    assert property (data_reset_o[*2] |-> event_count_o == '0) else $error("count kept");
  chk_ack_lamp:
    assert property (wb_ack_o |-> ##[0:1] access_ack_indicator_o) else $error("ack lamp");
  chk_hw_reset:
    assert property (disable iff (1'b0) rst_i ##1 rst_i |-> data_reset_o && soft_reset_o)
      else $error("hw reset");
  chk_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule
bind abrc_top abrc_monitor #(.CONV_CYC(CONV_CYC), .CNT_W(CNT_W), .EVENTS(EVENTS)) u_mon (
  .clk_i, .rst_i, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .busy_line_o,
  .busy_line_oe_n_o, .data_ready_line_o, .data_ready_line_oe_n_o, .conv_start_o,
  .data_reset_o, .soft_reset_o, .busy_lamp_o, .access_ack_indicator_o, .event_count_o);

//--- bench/test_acquisition_busy_reset_control.sv
// Self-checking bench for the busy, reset and fast-abort control
`timescale 1ns/1ps
module test_acquisition_busy_reset_control;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic [7:0]       wb_adr_i = 8'h00;
  logic [31:0]      wb_dat_i = 32'h0000_0000;
  logic [3:0]       wb_sel_i = 4'hf;
  logic             wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic             panel_common_in_i = 1'b0, common_start_stop_in_i = 1'b0;
  logic             veto_i = 1'b0, fast_abort_in_i = 1'b0, panel_reset_i = 1'b0;
  logic             busy_scope_select_i = 1'b0, event_stored_i = 1'b0, peer = 1'b0;
  logic             event_read_i = 1'b0, analog_reset_i = 1'b0;
  logic [6:0]       term_set_i = 7'h7f;
  logic [31:0]      seed = 32'h0000_1c33, rd, r;
  wire logic        busy_line_i, data_ready_line_i, wb_ack_o, busy_line_o, busy_line_oe_n_o;
  wire logic        data_ready_line_o, data_ready_line_oe_n_o, acq_stop_o, conv_start_o;
  wire logic        tac_clear_o, data_reset_o, soft_reset_o, busy_lamp_o, ready_lamp_o;
  wire logic        access_ack_indicator_o, term_green_o, term_red_o;
  wire logic [31:0] wb_dat_o;
  wire logic [23:0] event_count_o;
  wire logic [5:0]  o = {soft_reset_o, data_reset_o, tac_clear_o, acq_stop_o, conv_start_o,
                         busy_line_o};
  int               num_errors = 0, tests_run = 0;

  abrc_top #(.CONV_CYC(40)) DUT (.*);
  abrc_board_model u_peer (.own_busy_i(busy_line_o), .own_busy_oe_n_i(busy_line_oe_n_o),
    .own_ready_i(data_ready_line_o), .own_ready_oe_n_i(data_ready_line_oe_n_o),
    .peer_busy_i(peer), .peer_ready_i(1'b0), .busy_wire_o(busy_line_i),
    .ready_wire_o(data_ready_line_i));

  initial forever #12.5 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] st_exp(input logic gb, b, br, ob);
    return {28'h000_0000, gb, b, br, ob};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Request held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    n = 0;
    do begin tick(1); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    tick(1);
    if (n == 50) begin check(n, 0); test_done(); end
  endtask
  task automatic wait_bit(input int i, input logic v);
    int n;
    n = 0;
    while (o[i] !== v && n < 200) begin tick(1); n++; end
    check(o[i], v);
    if (n == 200) test_done();
  endtask
  // Common pulse wide enough for the input synchroniser
  task automatic common(input logic panel);
    if (panel) panel_common_in_i <= 1'b1; else common_start_stop_in_i <= 1'b1;
    tick(2);
    panel_common_in_i <= 1'b0; common_start_stop_in_i <= 1'b0;
  endtask

  initial begin
    tick(6);
    rst_i <= 1'b0;
    tick(1);
    check({term_green_o, term_red_o, busy_lamp_o, ready_lamp_o}, 4'hf);
    bus(0, abrc_pkg::ADDR_SET2, 0); check(rd, 32'h0000_4000);
    bus(0, abrc_pkg::ADDR_FCWIN, 0); check(rd, 32'h0000_0010);
    bus(0, 8'h3c, 0); check(rd, 0);
    r = rnd() & 32'h0000_ffff;
    bus(1, abrc_pkg::ADDR_FCWIN, r); bus(0, abrc_pkg::ADDR_FCWIN, 0); check(rd, r);
    bus(1, abrc_pkg::ADDR_FCWIN, 32'h0000_0020);
    common(1); wait_bit(1, 1);
    tick(1); common(0); tick(6);
    bus(0, abrc_pkg::ADDR_STATUS1, 0); check(rd & 15, st_exp(1, 1, 0, 0));
    wait_bit(0, 0);
    bus(0, abrc_pkg::ADDR_EVCNT, 0); check(rd, 2);
    bus(1, abrc_pkg::ADDR_CLR2, 32'h0000_4000);
    veto_i <= 1'b1; common(0); tick(8); check(o[0], 0); veto_i <= 1'b0;
    common(0); wait_bit(1, 1); fast_abort_in_i <= 1'b1; tick(2); fast_abort_in_i <= 1'b0;
    wait_bit(3, 1);
    common(0); // gate inside hold-off must be ignored
    wait_bit(0, 0);
    tick(24);
    bus(0, abrc_pkg::ADDR_EVCNT, 0); check(rd, 3);
    event_stored_i <= 1'b1; tick(1); event_stored_i <= 1'b0; tick(5);
    bus(0, abrc_pkg::ADDR_STATUS1, 0); check(rd & 15, st_exp(0, 0, 1, 1));
    event_read_i <= 1'b1; tick(1); event_read_i <= 1'b0; tick(3);
    check(data_ready_line_oe_n_o, 1);
    busy_scope_select_i <= 1'b1; peer <= 1'b1; wait_bit(2, 1);
    busy_scope_select_i <= 1'b0; wait_bit(2, 0); peer <= 1'b0;
    bus(1, abrc_pkg::ADDR_SET1, 32'h0000_0008); wait_bit(0, 1);
    bus(1, abrc_pkg::ADDR_CLR1, 32'h0000_0008); wait_bit(0, 0);
    analog_reset_i <= 1'b1; wait_bit(0, 1); analog_reset_i <= 1'b0; wait_bit(0, 0);
    bus(1, abrc_pkg::ADDR_SET2, 32'h0000_0004); check(o[5:4], 2'b01);
    bus(0, abrc_pkg::ADDR_EVCNT, 0); check(rd, 0);
    bus(1, abrc_pkg::ADDR_CLR2, 32'h0000_0004); wait_bit(4, 0);
    bus(1, abrc_pkg::ADDR_SET1, 32'h0000_0080); check(o[5], 1);
    bus(1, abrc_pkg::ADDR_CLR1, 32'h0000_0008); check(o[5], 1);
    bus(1, abrc_pkg::ADDR_CLR1, 32'h0000_0080); wait_bit(5, 0);
    bus(0, abrc_pkg::ADDR_FCWIN, 0); check(rd, 32'h0000_0010);
    panel_reset_i <= 1'b1; wait_bit(4, 1); check(o[5], 0); panel_reset_i <= 1'b0;
    wait_bit(4, 0);
    bus(1, abrc_pkg::ADDR_CTRL1, 32'h0000_0010);
    panel_reset_i <= 1'b1; wait_bit(5, 1); panel_reset_i <= 1'b0; wait_bit(5, 0);
    bus(1, abrc_pkg::ADDR_SINGLE, rnd()); tick(1); check(o[5], 0);
    rst_i <= 1'b1; tick(3); check(o[5:4], 2'b11); rst_i <= 1'b0;
    tick(2);
    test_done();
  end
endmodule

//--- design/abrc_top.sv
// Busy, data-ready, reset and fast-abort control with a Wishbone slave
`timescale 1ns/1ps
module abrc_top #(
  parameter int CONV_CYC  = 228,
  parameter int CNT_W     = 24,
  parameter int EVENTS    = 32
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        panel_common_in_i,
  input  wire logic        common_start_stop_in_i,
  input  wire logic        veto_i,
  input  wire logic        fast_abort_in_i,
  input  wire logic        panel_reset_i,
  input  wire logic        busy_line_i,
  input  wire logic        data_ready_line_i,
  input  wire logic        busy_scope_select_i,
  input  wire logic        event_stored_i,
  input  wire logic        event_read_i,
  input  wire logic        analog_reset_i,
  input  wire logic [6:0]  term_set_i,
  output logic             busy_line_o,
  output logic             busy_line_oe_n_o,
  output logic             data_ready_line_o,
  output logic             data_ready_line_oe_n_o,
  output logic             acq_stop_o,
  output logic             conv_start_o,
  output logic             tac_clear_o,
  output logic             data_reset_o,
  output logic             soft_reset_o,
  output logic             busy_lamp_o,
  output logic             ready_lamp_o,
  output logic             access_ack_indicator_o,
  output logic             term_green_o,
  output logic             term_red_o,
  output logic [CNT_W-1:0] event_count_o
);
  localparam int PW = $clog2(EVENTS);

  // Two-flop synchronisers; the first stage is read only by the second
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_c;
  always_ff @(posedge clk_i) begin
    sync_a <= {panel_reset_i, fast_abort_in_i, veto_i,
               panel_common_in_i | common_start_stop_in_i, busy_line_i};
    sync_b <= sync_a;
    sync_c <= sync_b;
  end
  logic data_ready_line_a;
  logic data_ready_line_b;
  always_ff @(posedge clk_i) begin
    data_ready_line_a <= data_ready_line_i;
    data_ready_line_b <= data_ready_line_a;
  end

  logic common_rise;
  logic fast_abort_in_rise;
  logic prst_rise;
  logic veto_s;
  logic gbusy_s;
  assign common_rise = sync_b[1] & ~sync_c[1];
  assign fast_abort_in_rise   = sync_b[3] & ~sync_c[3];
  assign prst_rise   = sync_b[4] & ~sync_c[4];
  assign veto_s      = sync_b[2];
  assign gbusy_s     = sync_b[0];

  // Register file
  logic [15:0] ctrl1;
  logic [15:0] set1;
  logic [15:0] set2;
  logic [15:0] fcwin;
  logic        bus_req;
  logic        bus_wr;
  logic        single_shot;
  assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr      = bus_req & wb_we_i;
  assign single_shot = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == abrc_pkg::ADDR_SINGLE);

  logic hard_rst;
  logic soft_rst;
  logic data_rst;
  logic panel_soft;
  logic panel_data;
  assign hard_rst   = rst_i;
  assign panel_soft = prst_rise & ctrl1[abrc_pkg::CTRL1_PRST];
  assign panel_data = prst_rise & ~ctrl1[abrc_pkg::CTRL1_PRST];
  assign soft_rst   = hard_rst | set1[abrc_pkg::SET1_SWRST] | single_shot | panel_soft;
  assign data_rst   = soft_rst | set2[abrc_pkg::SET2_CLRD] | panel_data;

  function automatic logic wr_hit(input logic [7:0] a);
    return bus_wr & (wb_adr_i == a);
  endfunction

  always_ff @(posedge clk_i) begin
    if (hard_rst) begin
      ctrl1 <= 16'h0000;
    end else begin
      if (wr_hit(abrc_pkg::ADDR_CTRL1) && wb_sel_i[0]) ctrl1[7:0] <= wb_dat_i[7:0];
      if (wr_hit(abrc_pkg::ADDR_CTRL1) && wb_sel_i[1]) ctrl1[15:8] <= wb_dat_i[15:8];
    end
  end

  // Set and clear share one word; both writes cannot fall in one cycle
  always_ff @(posedge clk_i) begin
    if (hard_rst) begin
      set1 <= 16'h0000;
    end else begin
      if (wr_hit(abrc_pkg::ADDR_SET1)) set1 <= set1 | wb_dat_i[15:0];
      else if (wr_hit(abrc_pkg::ADDR_CLR1)) set1 <= set1 & ~wb_dat_i[15:0];
    end
  end

  // Soft-resettable group; clear-data bit is held by the reset itself
  always_ff @(posedge clk_i) begin
    if (hard_rst || (soft_rst && !set2[abrc_pkg::SET2_CLRD])) begin
      set2  <= abrc_pkg::SET2_RESET;
      fcwin <= abrc_pkg::FCWIN_RESET;
    end else begin
      if (wr_hit(abrc_pkg::ADDR_SET2)) set2 <= set2 | wb_dat_i[15:0];
      else if (wr_hit(abrc_pkg::ADDR_CLR2)) set2 <= set2 & ~wb_dat_i[15:0];
      if (wr_hit(abrc_pkg::ADDR_FCWIN)) fcwin <= wb_dat_i[15:0];
    end
  end

  // Event buffer pointers with full/empty by last increment
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic          last_wr;
  logic          buf_full;
  logic          buf_data;
  assign buf_full = (wr_ptr == rd_ptr) & last_wr;
  assign buf_data = (wr_ptr != rd_ptr) | last_wr;
  always_ff @(posedge clk_i) begin
    if (data_rst) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      last_wr <= 1'b0;
    end else begin
      // Store and read in one cycle keep the fill level, except on an empty buffer where only the store counts
      if (event_stored_i && (!buf_full || event_read_i)) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (event_read_i && buf_data) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (event_stored_i && !buf_full && !(event_read_i && buf_data)) begin
        last_wr <= 1'b1;
      end else if (event_read_i && buf_data && !event_stored_i) begin
        last_wr <= 1'b0;
      end
    end
  end

  // Conversion sequencer
  abrc_pkg::abrc_state_t state;
  logic [15:0] cnt;
  logic [15:0] win_cnt;
  logic        own_busy;
  logic        stop_acq;
  logic        accept;
  logic        fast_abort_in_ok;
  assign own_busy = (state != abrc_pkg::ABRC_IDLE) | analog_reset_i | buf_full
                  | set1[abrc_pkg::SET1_MTEST] | data_rst;
  assign stop_acq = busy_scope_select_i ? (own_busy | gbusy_s) : own_busy;
  assign accept   = common_rise & ~stop_acq & ~veto_s;
  assign fast_abort_in_ok  = fast_abort_in_rise & (state == abrc_pkg::ABRC_CONV) & (win_cnt < fcwin);

  always_ff @(posedge clk_i) begin
    if (data_rst) begin
      state   <= abrc_pkg::ABRC_IDLE;
      cnt     <= '0;
    end else begin
      case (state)
        abrc_pkg::ABRC_IDLE: begin
          if (accept) begin
            state   <= abrc_pkg::ABRC_CONV;
            cnt     <= '0;
          end
        end
        abrc_pkg::ABRC_CONV: begin
          if (fast_abort_in_ok) begin
            state <= abrc_pkg::ABRC_CLEAR;
            cnt   <= '0;
          end else if (cnt == 16'(CONV_CYC - 1)) begin
            state <= abrc_pkg::ABRC_IDLE;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        abrc_pkg::ABRC_CLEAR: begin
          if (cnt == 16'(abrc_pkg::FAST_ABORT_IN_HOLD_CYC - 2)) state <= abrc_pkg::ABRC_IDLE;
          else cnt <= cnt + 16'h0001;
        end
        default: state <= abrc_pkg::ABRC_IDLE;
      endcase
    end
  end

  // window counter; saturates so a long window never wraps open again
  always_ff @(posedge clk_i) begin
    if (data_rst) begin
      win_cnt <= '0;
    end else if (state == abrc_pkg::ABRC_IDLE) begin
      win_cnt <= '0;
    end else if (state == abrc_pkg::ABRC_CONV && win_cnt != 16'hFFFF) begin
      win_cnt <= win_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (data_rst) begin
      event_count_o <= '0;
    end else if (set2[abrc_pkg::SET2_ALLTRG] ? common_rise : accept) begin
      event_count_o <= event_count_o + 1'b1;
    end
  end

  // Power-up configuration and access lamp timers
  logic [11:0] cfg_cnt;
  logic [10:0] ack_cnt;
  logic        cfg;
  assign cfg = cfg_cnt != 12'h0000;
  // Configuration window restarts with every hardware reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_cnt <= 12'(abrc_pkg::CONFIG_CYC);
    end else if (cfg) begin
      cfg_cnt <= cfg_cnt - 12'h001;
    end
  end
  // Stretched so a single access stays visible on the lamp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_cnt <= '0;
    end else if (bus_req) begin
      ack_cnt <= 11'(abrc_pkg::ACK_LAMP_CYC);
    end else if (ack_cnt != 11'h000) begin
      ack_cnt <= ack_cnt - 11'h001;
    end
  end

  logic all_term;
  logic no_term;
  assign all_term = &term_set_i;
  assign no_term  = ~|term_set_i;

  // busy outputs; open-drain style, driven only when active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_line_o      <= 1'b0;
      busy_line_oe_n_o <= 1'b1;
    end else begin
      busy_line_o      <= own_busy;
      busy_line_oe_n_o <= ~own_busy;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_ready_line_o      <= 1'b0;
      data_ready_line_oe_n_o <= 1'b1;
    end else begin
      data_ready_line_o      <= buf_data;
      data_ready_line_oe_n_o <= ~buf_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acq_stop_o   <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      acq_stop_o   <= stop_acq | veto_s;
      conv_start_o <= accept;
    end
  end

  // clear on abort; reset outputs stay high through hardware reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tac_clear_o  <= 1'b1;
      data_reset_o <= 1'b1;
      soft_reset_o <= 1'b1;
    end else begin
      tac_clear_o  <= data_rst | fast_abort_in_ok;
      data_reset_o <= data_rst;
      soft_reset_o <= soft_rst;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_lamp_o            <= 1'b1;
      ready_lamp_o           <= 1'b1;
      access_ack_indicator_o <= 1'b0;
    end else begin
      busy_lamp_o            <= own_busy | cfg;
      ready_lamp_o           <= buf_data | cfg;
      access_ack_indicator_o <= ack_cnt != 11'h000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_green_o <= 1'b1;
      term_red_o   <= 1'b1;
    end else begin
      term_green_o <= cfg | all_term;
      term_red_o   <= cfg | no_term;
    end
  end

  // Wishbone answer: one cycle after request, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read word built in the request cycle so it stands with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else begin
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          abrc_pkg::ADDR_STATUS1: begin
            wb_dat_o[abrc_pkg::ST_DATA_READY_LINE]  <= buf_data;
            wb_dat_o[abrc_pkg::ST_GDRDY] <= data_ready_line_b | buf_data;
            wb_dat_o[abrc_pkg::ST_BUSY]  <= own_busy;
            wb_dat_o[abrc_pkg::ST_GBUSY] <= gbusy_s | own_busy;
            wb_dat_o[abrc_pkg::ST_FULL]  <= buf_full;
          end
          abrc_pkg::ADDR_CTRL1:  wb_dat_o[15:0] <= ctrl1;
          abrc_pkg::ADDR_SET1:   wb_dat_o[15:0] <= set1;
          abrc_pkg::ADDR_CLR1:   wb_dat_o[15:0] <= set1;
          abrc_pkg::ADDR_SET2:   wb_dat_o[15:0] <= set2;
          abrc_pkg::ADDR_CLR2:   wb_dat_o[15:0] <= set2;
          abrc_pkg::ADDR_FCWIN:  wb_dat_o[15:0] <= fcwin;
          abrc_pkg::ADDR_EVCNT:  wb_dat_o[CNT_W-1:0] <= event_count_o;
          default:               wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule

//--- include/abrc_pkg.sv
// Package of constants for the acquisition busy and reset control block
package abrc_pkg;
  localparam logic [7:0] ADDR_STATUS1   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1     = 8'h04;
  localparam logic [7:0] ADDR_SET1      = 8'h08;
  localparam logic [7:0] ADDR_CLR1      = 8'h0C;
  localparam logic [7:0] ADDR_SINGLE    = 8'h10;
  localparam logic [7:0] ADDR_SET2      = 8'h14;
  localparam logic [7:0] ADDR_CLR2      = 8'h18;
  localparam logic [7:0] ADDR_FCWIN     = 8'h1C;
  localparam logic [7:0] ADDR_EVCNT     = 8'h20;
  localparam int ST_DATA_READY_LINE    = 0;
  localparam int ST_GDRDY   = 1;
  localparam int ST_BUSY    = 2;
  localparam int ST_GBUSY   = 3;
  localparam int ST_FULL    = 4;
  localparam int CTRL1_PRST = 4;
  localparam int SET1_SWRST = 7;
  localparam int SET1_MTEST = 3;
  localparam int SET2_CLRD  = 2;
  localparam int SET2_ALLTRG = 14;
  localparam logic [15:0] SET2_RESET = 16'h4000;
  localparam logic [15:0] FCWIN_RESET = 16'h0010;
  localparam int CLK_MHZ        = 40;
  localparam int FAST_ABORT_IN_HOLD_NS   = 600;
  localparam int FAST_ABORT_IN_HOLD_CYC  = (FAST_ABORT_IN_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CONFIG_CYC     = 4000;
  localparam int ACK_LAMP_CYC   = 2000;
  typedef enum logic [1:0] {
    ABRC_IDLE  = 2'b00,
    ABRC_CONV  = 2'b01,
    ABRC_CLEAR = 2'b10
  } abrc_state_t;
endpackage
